// [cpm_pkg.sv]
// Constants, register map and types for the control pin mode decoder.
package cpm_pkg;

  // Clock and timing, each time in ns as a figure, then derived cycles.
  localparam int CLK_PERIOD_NS    = 100;
  localparam int CAL_DLY_SHORT_NS = 1000;
  localparam int CAL_DLY_LONG_NS  = 100000;
  localparam int CAL_RUN_NS       = 50000;
  localparam int CNT_W            = 10;
  localparam logic [CNT_W-1:0] CAL_DLY_SHORT_CYC =
    CNT_W'((CAL_DLY_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CAL_DLY_LONG_CYC =
    CNT_W'((CAL_DLY_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CAL_RUN_CYC =
    CNT_W'((CAL_RUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [CNT_W-1:0] CNT_ONE  = 10'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;

  // Synchroniser bit positions of the pin inputs.
  localparam int SYNC_W       = 7;
  localparam int SY_ECE       = 0;
  localparam int SY_DRST      = 1;
  localparam int SY_SH_HI     = 2;
  localparam int SY_SH_LO     = 3;
  localparam int SY_RLGN      = 4;
  localparam int SY_CM_GND    = 5;
  localparam int SY_CAL_DLY   = 6;
  // Pins idle as pin control, single-ended realign and a high shared pin,
  // which is what the mode registers reset to.
  localparam logic [SYNC_W-1:0] SYNC_RST = 7'h07;

  // AHB-Lite register map, byte addresses within the decoded window.
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
  localparam logic [ADDR_W-1:0] FSADJ_OFS  = 8'h04;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h08;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;
  localparam logic [31:0] WORD_ZERO  = 32'h00000000;

  // Field layouts and reset values.
  localparam int CTRL_CAL_START = 0;
  localparam int FSADJ_W        = 8;
  localparam logic [FSADJ_W-1:0] FSADJ_RST = 8'h80;
  localparam int ST_CAL_ACTIVE  = 0;
  localparam int ST_EXT_MODE    = 1;
  localparam int ST_DIFF_RLGN   = 2;
  localparam int ST_RANGE_HIGH  = 3;
  localparam int ST_AC_COUPLE   = 4;
  localparam int ST_SERIAL_SEL  = 5;
  localparam int ST_ALT_REQ     = 6;
  localparam int ST_DLY_LONG    = 7;
  localparam int ST_W           = 8;

  // Calibration sequencer states, Gray coded along wait, run, idle.
  typedef enum logic [1:0] {
    CAL_WAIT = 2'h0,
    CAL_RUN  = 2'h1,
    CAL_IDLE = 2'h3
  } cpm_cal_state_e;

endpackage : cpm_pkg

// [cpm_control_pin_decoder.sv]
// Control pin mode decoder with calibration sequencer and AHB-Lite slave.
// What this block does
// RULE1 - The calibration indicator is high exactly while calibration runs.
// RULE2 - A high extended-control select pin turns extended control off.
// RULE3 - A low extended-control select pin turns extended control on and lets the full-scale adjust register be written.
// RULE4 - The dedicated select pin overrides the shared-pin alternate select.
// RULE5 - A floating or high realign-style pin gives single-ended realign and a shared pin used for range or alternate select.
// RULE6 - A low realign-style pin makes realign differential, the shared pin being its negative half.
// RULE7 - Differential realign ignores pin range selection and forces the higher range.
// RULE8 - A grounded common-mode pin selects AC coupling, otherwise the common-mode voltage is driven for DC coupling.
// RULE9 - As range select, a low shared pin gives the reduced range and a high one the higher range.
// RULE10 - As alternate select, a mid or floating shared pin requests extended control.
// RULE11 - A floating shared pin with the select pin low makes the delay pin the serial chip select and forces the short delay.
// RULE12 - The shared pin is classed low, high or mid, and all mode bits but the common-mode drive leave as synchronised registers.
//
// Our own choices: register access over AHB-Lite and the address map.
module cpm_control_pin_decoder
  import cpm_pkg::*;
(
  // Clock and reset.
  input  wire logic               ref_clk_i,
  input  wire logic               sys_rst_i,
  // Control pins, asynchronous to the clock.
  input  wire logic               extended_ctrl_select_i,
  input  wire logic               realign_style_select_i,
  input  wire logic               shared_pin_high_i,
  input  wire logic               shared_pin_low_i,
  input  wire logic               output_clock_realign_i,
  input  wire logic               common_mode_grounded_i,
  input  wire logic               calibration_delay_select_i,
  // Resolved modes towards the converter core.
  output logic                    extended_ctrl_mode_o,
  output logic                    realign_differential_o,
  output logic                    realign_pulse_o,
  output logic                    range_high_o,
  output logic                    ac_coupling_o,
  output logic                    common_mode_out_en_o,
  output logic                    serial_chip_select_mode_o,
  output logic                    serial_chip_select_o,
  output logic                    secondary_extended_ctrl_select_o,
  output logic [FSADJ_W-1:0]      full_scale_adjust_o,
  output logic                    calibration_active_flag_o,
  // AHB-Lite slave.
  input  wire logic               hsel_i,
  input  wire logic [31:0]        haddr_i,
  input  wire logic [1:0]         htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic [2:0]         hsize_i,
  input  wire logic [31:0]        hwdata_i,
  input  wire logic               hready_i,
  output logic                    hreadyout_o,
  output logic                    hresp_o,
  output logic [31:0]             hrdata_o
);

  // Pin vector gathered for the synchroniser.
  // Gathering lets one generate loop treat every pin alike.
  logic [SYNC_W-1:0] pin_vec;
  logic [SYNC_W-1:0] sync_a;
  logic [SYNC_W-1:0] sync_b;

  assign pin_vec[SY_ECE]     = extended_ctrl_select_i;
  assign pin_vec[SY_DRST]    = realign_style_select_i;
  assign pin_vec[SY_SH_HI]   = shared_pin_high_i;
  assign pin_vec[SY_SH_LO]   = shared_pin_low_i;
  assign pin_vec[SY_RLGN]    = output_clock_realign_i;
  assign pin_vec[SY_CM_GND]  = common_mode_grounded_i;
  assign pin_vec[SY_CAL_DLY] = calibration_delay_select_i;

  // Two flip-flops per pin; only sync_b is read by the decode.
  // The reset value matches the mode registers, so no false mid level
  // of the shared pin reaches the decode in the cycles after reset.
  for (genvar g = 0; g < SYNC_W; g++) begin : g_sync
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
        sync_a[g] <= SYNC_RST[g];
        sync_b[g] <= SYNC_RST[g];
      end else begin
        sync_a[g] <= pin_vec[g]; // RULE12
        sync_b[g] <= sync_a[g];
      end
    end
  end

  // Mode state registers.
  // Every mode bit but the common-mode drive leaves the block from a flip-flop of its own.
  logic ext_mode;
  logic diff_mode;
  logic rlgn_pulse;
  logic range_high;
  logic ac_mode;
  logic serial_mode;
  logic serial_cs;
  logic alt_req;
  logic dly_long;
  logic next_ext_mode;
  logic next_diff_mode;
  logic next_rlgn_pulse;
  logic next_range_high;
  logic next_ac_mode;
  logic next_serial_mode;
  logic next_serial_cs;
  logic next_alt_req;
  logic next_dly_long;
  logic sh_mid;

  // Decode the synchronised pins into mode bits.
  always_comb begin
    // Neither comparator tripped means the pin floats near mid-supply.
    sh_mid          = ~sync_b[SY_SH_HI] & ~sync_b[SY_SH_LO]; // RULE12
    next_diff_mode  = ~sync_b[SY_DRST]; // RULE5 RULE6
    // The dedicated pin alone decides; the alternate is only reported.
    next_ext_mode   = ~sync_b[SY_ECE]; // RULE2 RULE3 RULE4
    next_alt_req    = ~next_diff_mode & sh_mid; // RULE10 RULE5
    next_serial_mode = next_alt_req & ~sync_b[SY_ECE]; // RULE11
    next_serial_cs  = next_serial_mode & sync_b[SY_CAL_DLY]; // RULE11
    next_dly_long   = ~next_serial_mode & sync_b[SY_CAL_DLY]; // RULE11
    next_ac_mode    = sync_b[SY_CM_GND]; // RULE8
    // A mid shared pin leaves the last range in place, and the range
    // pin is ignored altogether while realign is differential.
    next_range_high = range_high;
    if (next_diff_mode) begin
      next_range_high = 1'b1; // RULE7
    end else if (sync_b[SY_SH_HI]) begin
      next_range_high = 1'b1; // RULE9
    end else if (sync_b[SY_SH_LO]) begin
      next_range_high = 1'b0; // RULE9
    end
    // Differential realign needs the positive half high, negative low.
    if (next_diff_mode) begin
      next_rlgn_pulse = sync_b[SY_RLGN] & sync_b[SY_SH_LO]; // RULE6
    end else begin
      next_rlgn_pulse = sync_b[SY_RLGN]; // RULE5
    end
  end

  // Register the decoded modes.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ext_mode    <= 1'b0;
      diff_mode   <= 1'b0;
      rlgn_pulse  <= 1'b0;
      range_high  <= 1'b1;
      ac_mode     <= 1'b0;
      serial_mode <= 1'b0;
      serial_cs   <= 1'b0;
      alt_req     <= 1'b0;
      dly_long    <= 1'b0;
    end else begin
      ext_mode    <= next_ext_mode;
      diff_mode   <= next_diff_mode;
      rlgn_pulse  <= next_rlgn_pulse;
      range_high  <= next_range_high;
      ac_mode     <= next_ac_mode;
      serial_mode <= next_serial_mode;
      serial_cs   <= next_serial_cs;
      alt_req     <= next_alt_req;
      dly_long    <= next_dly_long;
    end
  end

  // Bus data-phase state and register file.
  // Only the low address byte is decoded, so the map repeats upwards.
  logic              dp_write;
  logic [ADDR_W-1:0] dp_addr;
  logic [FSADJ_W-1:0] fs_adjust;
  logic [31:0]       rdata;
  logic              next_dp_write;
  logic [ADDR_W-1:0] next_dp_addr;
  logic [FSADJ_W-1:0] next_fs_adjust;
  logic [31:0]       next_rdata;
  logic              addr_phase;
  logic              cal_start;
  logic [ST_W-1:0]   status_word;

  // Calibration sequencer state.
  cpm_cal_state_e   cal_state;
  cpm_cal_state_e   next_cal_state;
  logic [CNT_W-1:0] cal_cnt;
  logic [CNT_W-1:0] next_cal_cnt;
  logic [CNT_W-1:0] dly_limit;
  logic             cal_flag;
  logic             next_cal_flag;

  // Status word as seen by software.
  // Unused upper bits read as zero.
  always_comb begin
    status_word                = '0;
    status_word[ST_CAL_ACTIVE] = cal_flag;
    status_word[ST_EXT_MODE]   = ext_mode;
    status_word[ST_DIFF_RLGN]  = diff_mode;
    status_word[ST_RANGE_HIGH] = range_high;
    status_word[ST_AC_COUPLE]  = ac_mode;
    status_word[ST_SERIAL_SEL] = serial_mode;
    status_word[ST_ALT_REQ]    = alt_req;
    status_word[ST_DLY_LONG]   = dly_long;
  end

  // Address phase capture, read data and register writes.
  // Read data are formed in the address phase and registered, so they
  // stand on hrdata_o for the whole data phase without a wait state.
  always_comb begin
    addr_phase     = hsel_i & hready_i & htrans_i[1]
                     & (hsize_i == HSIZE_WORD);
    next_dp_write  = addr_phase & hwrite_i;
    next_dp_addr   = addr_phase ? haddr_i[ADDR_W-1:0] : dp_addr;
    next_rdata     = WORD_ZERO;
    if (addr_phase && !hwrite_i) begin
      case (haddr_i[ADDR_W-1:0])
        FSADJ_OFS:  next_rdata = {{(32-FSADJ_W){1'b0}}, fs_adjust};
        STATUS_OFS: next_rdata = {{(32-ST_W){1'b0}}, status_word};
        default:    next_rdata = WORD_ZERO;
      endcase
    end
    cal_start      = dp_write && (dp_addr == CTRL_OFS)
                     && hwdata_i[CTRL_CAL_START];
    next_fs_adjust = fs_adjust;
    // Pin-only control locks the adjust register against writes.
    if (dp_write && (dp_addr == FSADJ_OFS) && ext_mode) begin
      next_fs_adjust = hwdata_i[FSADJ_W-1:0]; // RULE3
    end
  end

  // Register the bus state.
  // The adjust register keeps its value through pin-only operation.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dp_write  <= 1'b0;
      dp_addr   <= CTRL_OFS;
      fs_adjust <= FSADJ_RST;
      rdata     <= WORD_ZERO;
    end else begin
      dp_write  <= next_dp_write;
      dp_addr   <= next_dp_addr;
      fs_adjust <= next_fs_adjust;
      rdata     <= next_rdata;
    end
  end

  // Power-up delay then calibration; software may restart it when idle.
  // The delay limit is read every cycle, so a delay pin change during
  // the wait shortens or stretches it; a start outside idle is dropped.
  always_comb begin
    dly_limit      = dly_long ? CAL_DLY_LONG_CYC : CAL_DLY_SHORT_CYC;
    next_cal_state = cal_state;
    next_cal_cnt   = cal_cnt + CNT_ONE;
    case (cal_state)
      CAL_WAIT: begin
        if (cal_cnt >= dly_limit - CNT_ONE) begin
          next_cal_state = CAL_RUN;
          next_cal_cnt   = CNT_ZERO;
        end
      end
      CAL_RUN: begin
        if (cal_cnt >= CAL_RUN_CYC - CNT_ONE) begin
          next_cal_state = CAL_IDLE;
          next_cal_cnt   = CNT_ZERO;
        end
      end
      CAL_IDLE: begin
        next_cal_cnt = CNT_ZERO;
        if (cal_start) begin
          next_cal_state = CAL_RUN;
        end
      end
      default: begin
        next_cal_state = CAL_WAIT;
        next_cal_cnt   = CNT_ZERO;
      end
    endcase
    next_cal_flag = (next_cal_state == CAL_RUN); // RULE1
  end

  // Register the sequencer.
  // The flag is registered from the next state, so it stands exactly
  // while the state is the run state.
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cal_state <= CAL_WAIT;
      cal_cnt   <= CNT_ZERO;
      cal_flag  <= 1'b0;
    end else begin
      cal_state <= next_cal_state;
      cal_cnt   <= next_cal_cnt;
      cal_flag  <= next_cal_flag;
    end
  end

  // Outputs, all straight from flip-flops except the common-mode drive and the bus handshake.
  // The common-mode drive is the inverse of AC coupling, never both.
  assign extended_ctrl_mode_o             = ext_mode;
  assign realign_differential_o           = diff_mode;
  assign realign_pulse_o                  = rlgn_pulse;
  assign range_high_o                     = range_high;
  assign ac_coupling_o                    = ac_mode; // RULE8
  assign common_mode_out_en_o             = ~ac_mode; // RULE8
  assign serial_chip_select_mode_o        = serial_mode;
  assign serial_chip_select_o             = serial_cs;
  assign secondary_extended_ctrl_select_o = alt_req;
  assign full_scale_adjust_o              = fs_adjust;
  assign calibration_active_flag_o        = cal_flag; // RULE1
  assign hreadyout_o                      = 1'b1; // No wait states.
  assign hresp_o                          = 1'b0; // Always OKAY.
  assign hrdata_o                         = rdata;

endmodule : cpm_control_pin_decoder

// [cpm_strap_model.sv]
// Board strap model that drives the control pins of the decoder.
module cpm_strap_model
  import cpm_pkg::*;
(
  // Strap word: select, style, shared level, ground, delay, realign.
  input  wire logic [6:0] strap_i,
  // Pin levels seen by the decoder.
  output logic            extended_ctrl_select_o,
  output logic            realign_style_select_o,
  output logic            shared_pin_high_o,
  output logic            shared_pin_low_o,
  output logic            common_mode_grounded_o,
  output logic            calibration_delay_select_o,
  output logic            output_clock_realign_o
);
  // Shared level 0 is low, 1 is high, anything else floats at mid-supply.
  always_comb begin
    extended_ctrl_select_o     = strap_i[0];
    realign_style_select_o     = strap_i[1];
    shared_pin_low_o           = strap_i[3:2] == 2'h0;
    shared_pin_high_o          = strap_i[3:2] == 2'h1;
    common_mode_grounded_o     = strap_i[4];
    calibration_delay_select_o = strap_i[5];
    output_clock_realign_o     = strap_i[6];
  end
endmodule : cpm_strap_model

// [cpm_control_pin_monitor.sv]
// Port assertions for the control pin mode decoder.
module cpm_control_pin_monitor
  import cpm_pkg::*;
(
  // Clock, reset and pins.
  input wire logic               ref_clk_i,
  input wire logic               sys_rst_i,
  input wire logic               extended_ctrl_select_i,
  input wire logic               realign_style_select_i,
  input wire logic               shared_pin_high_i,
  input wire logic               shared_pin_low_i,
  input wire logic               output_clock_realign_i,
  input wire logic               common_mode_grounded_i,
  input wire logic               calibration_delay_select_i,
  // Resolved modes.
  input wire logic               extended_ctrl_mode_o,
  input wire logic               realign_differential_o,
  input wire logic               realign_pulse_o,
  input wire logic               range_high_o,
  input wire logic               ac_coupling_o,
  input wire logic               common_mode_out_en_o,
  input wire logic               serial_chip_select_mode_o,
  input wire logic               serial_chip_select_o,
  input wire logic               secondary_extended_ctrl_select_o,
  input wire logic [FSADJ_W-1:0] full_scale_adjust_o,
  input wire logic               calibration_active_flag_o,
  // Bus handshake.
  input wire logic               hreadyout_o,
  input wire logic               hresp_o
);
  logic [9:0] run_cnt;
  logic [9:0] next_run_cnt;
  logic       se_mid;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  // Single-ended realign with the shared pin at mid level.
  assign se_mid = realign_style_select_i && !shared_pin_high_i &&
                  !shared_pin_low_i;
  // Counts how long the calibration flag has been high.
  always_comb begin
    next_run_cnt = calibration_active_flag_o ? run_cnt + 10'h001 : 10'h000;
  end
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      run_cnt <= 10'h000;
    end else begin
      run_cnt <= next_run_cnt;
    end
  end
  a_ext_off_pin: assert property (extended_ctrl_select_i[*4] |->
    !extended_ctrl_mode_o) else $error("extended mode on with pin high");
  a_ext_on_pin: assert property (!extended_ctrl_select_i[*4] |->
    extended_ctrl_mode_o) else $error("extended mode off with pin low");
  a_single_realign: assert property (realign_style_select_i[*4] |->
    !realign_differential_o) else $error("realign not single-ended");
  a_diff_range: assert property (!realign_style_select_i[*4] |->
    realign_differential_o && range_high_o) else $error("diff realign bad");
  a_reduced_range: assert property (
    (realign_style_select_i && shared_pin_low_i)[*4] |-> !range_high_o)
    else $error("range not reduced");
  a_ac_select: assert property (common_mode_grounded_i[*4] |->
    ac_coupling_o) else $error("ac coupling not selected");
  a_cm_drive: assert property (ac_coupling_o != common_mode_out_en_o)
    else $error("common mode drive clashes with coupling");
  a_alt_request: assert property (se_mid[*4] |->
    secondary_extended_ctrl_select_o) else $error("alternate request lost");
  a_serial_mode: assert property (
    (se_mid && !extended_ctrl_select_i)[*4] |-> serial_chip_select_mode_o)
    else $error("serial select mode missing");
  a_cal_length: assert property ($fell(calibration_active_flag_o) |->
    run_cnt == 10'h1F4) else $error("calibration flag length wrong");
  a_single_pulse: assert property (realign_style_select_i[*4] |->
    realign_pulse_o == $past(output_clock_realign_i, 3))
    else $error("single-ended realign level wrong");
  a_diff_pulse: assert property (!realign_style_select_i[*4] |->
    realign_pulse_o == $past(output_clock_realign_i && shared_pin_low_i, 3))
    else $error("differential realign level wrong");
  a_serial_cs: assert property (
    (se_mid && !extended_ctrl_select_i)[*4] |->
    serial_chip_select_o == $past(calibration_delay_select_i, 3))
    else $error("serial chip select level wrong");
  a_dc_drive: assert property (!common_mode_grounded_i[*4] |->
    common_mode_out_en_o && !ac_coupling_o)
    else $error("common mode not driven for dc coupling");
  a_fs_locked: assert property (!extended_ctrl_mode_o |=>
    $stable(full_scale_adjust_o)) else $error("adjust written in pin mode");
  a_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus answer not ready and okay");
endmodule : cpm_control_pin_monitor
bind cpm_control_pin_decoder cpm_control_pin_monitor u_mon (.*);

// [cpm_testbench.sv]
// Self-checking testbench for the control pin mode decoder.
module testbench import cpm_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_i, sys_rst_i, extended_ctrl_select_i, realign_style_select_i;
  logic shared_pin_high_i, shared_pin_low_i, output_clock_realign_i;
  logic common_mode_grounded_i, calibration_delay_select_i;
  logic extended_ctrl_mode_o, realign_differential_o, realign_pulse_o;
  logic range_high_o, ac_coupling_o, common_mode_out_en_o, hresp_o;
  logic serial_chip_select_mode_o, serial_chip_select_o, hreadyout_o;
  logic secondary_extended_ctrl_select_o, calibration_active_flag_o;
  logic hsel_i, hwrite_i, hready_i, range_q;
  logic rd_dp = 1'b0;
  logic [FSADJ_W-1:0] full_scale_adjust_o;
  logic [31:0]        haddr_i, hwdata_i, hrdata_o, seed;
  logic [1:0]         htrans_i;
  logic [2:0]         hsize_i;
  logic [6:0]         strap_i;
  logic [31:0]        exp_q[$];
  int                 mismatches, checks_done, cyc;
  cpm_control_pin_decoder dut (.*);
  // The one slave's ready is the bus's ready.
  assign hready_i = hreadyout_o;
  cpm_strap_model u_strap (
    .strap_i                    (strap_i),
    .extended_ctrl_select_o     (extended_ctrl_select_i),
    .realign_style_select_o     (realign_style_select_i),
    .shared_pin_high_o          (shared_pin_high_i),
    .shared_pin_low_o           (shared_pin_low_i),
    .common_mode_grounded_o     (common_mode_grounded_i),
    .calibration_delay_select_o (calibration_delay_select_i),
    .output_clock_realign_o     (output_clock_realign_i)
  );
  // Free-running 10 MHz clock.
  initial begin
    ref_clk_i = 1'b0;
    forever #50 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr
  // Expected status word worked out from the strap levels.
  function automatic logic [31:0] exp_status(input logic [6:0] s);
    logic mid, ser;
    mid = s[3];
    ser = s[1] && mid && !s[0];
    if (!s[1] || !mid) begin
      range_q = !s[1] || s[2];
    end
    return {24'h0, s[5] && !ser, s[1] && mid, ser, s[4], range_q, !s[1],
            !s[0], 1'b0};
  endfunction : exp_status
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t read %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One AHB-Lite single word transfer, waiting on the ready answer.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i   <= 1'b1;
    haddr_i  <= {24'h0, a};
    hwrite_i <= w;
    htrans_i <= 2'h2;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    @(posedge ref_clk_i);
    while (hreadyout_o !== 1'b1) @(posedge ref_clk_i);
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic results;
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // Compares read data in each read data phase with the oldest note.
  always @(posedge ref_clk_i) begin
    if (rd_dp) begin
      check(hrdata_o, exp_q.pop_front());
    end
    rd_dp <= hsel_i && htrans_i[1] && !hwrite_i && hreadyout_o;
    cyc++;
    if (cyc == 4000) begin
      mismatches++;
      results();
    end
  end
  // Main sequence: reset, register access, random straps, calibration.
  initial begin
    {sys_rst_i, range_q, strap_i} = {2'h3, 7'h07};
    {hsel_i, hwrite_i, haddr_i, hwdata_i, htrans_i} = '0;
    hsize_i = HSIZE_WORD;
    seed = 32'h535CD4B9;
    repeat (5) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    repeat (600) @(posedge ref_clk_i);
    rd(STATUS_OFS, exp_status(strap_i));
    bus(1'b1, FSADJ_OFS, 32'h5A);
    rd(FSADJ_OFS, 32'h80);
    rd(8'h0C, 32'h0);
    // A byte-sized read is not taken and returns zero.
    hsize_i <= 3'h0;
    rd(STATUS_OFS, 32'h0);
    hsize_i <= HSIZE_WORD;
    strap_i <= 7'h06;
    repeat (4) @(posedge ref_clk_i);
    bus(1'b1, FSADJ_OFS, 32'h3C);
    rd(FSADJ_OFS, 32'h3C);
    for (int i = 0; i < 40; i++) begin
      seed = lfsr(seed);
      strap_i <= seed[6:0];
      repeat (4) @(posedge ref_clk_i);
      rd(STATUS_OFS, exp_status(seed[6:0]));
    end
    // Serial chip select mode, then a differential realign pulse.
    strap_i <= 7'h2A;
    repeat (4) @(posedge ref_clk_i);
    rd(STATUS_OFS, exp_status(7'h2A));
    strap_i <= 7'h41;
    repeat (4) @(posedge ref_clk_i);
    rd(STATUS_OFS, exp_status(7'h41));
    strap_i <= 7'h07;
    repeat (4) @(posedge ref_clk_i);
    bus(1'b1, CTRL_OFS, 32'h1);
    repeat (2) @(posedge ref_clk_i);
    rd(STATUS_OFS, exp_status(7'h07) | 32'h1);
    repeat (520) @(posedge ref_clk_i);
    rd(STATUS_OFS, exp_status(7'h07));
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    rd(FSADJ_OFS, 32'h80);
    repeat (2) @(posedge ref_clk_i);
    results();
  end
endmodule : testbench
